/* File: pot_pkg.sv */
package pot_pkg;
  localparam logic [4:0] DEV_ID_HI       = 5'h0a;
  localparam logic [7:0] REG_WIPER       = 8'h00;
  localparam logic [7:0] REG_ACCESS      = 8'h02;
  localparam logic [7:0] ACCESS_VOL_ONLY = 8'h80;
  localparam logic [6:0] WIPER_RST       = 7'h40;
  localparam logic [6:0] STORED_INIT_RST = 7'h40;
  localparam logic [6:0] WIPER_MAX       = 7'h7f;
  localparam int         CLK_MHZ         = 200;
  localparam int         NV_WRITE_MAX_MS = 20;
  localparam int         NV_WRITE_TYP_MS = 12;
  // Milliseconds to system clocks: 1000 us per ms, CLK_MHZ clocks per us
  localparam int         NV_WRITE_CYC    = NV_WRITE_TYP_MS * 1000 * CLK_MHZ;
  localparam int         POWERUP_CYC     = 16;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_in_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } bus_out_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ID    = 7'b0000010,
    ST_ACK   = 7'b0000100,
    ST_ADDR  = 7'b0001000,
    ST_WDATA = 7'b0010000,
    ST_RDATA = 7'b0100000,
    ST_RACK  = 7'b1000000
  } phase_t;
endpackage : pot_pkg

/* File: pot_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_pot_wiper_slave
  import pot_pkg::*;
#(
  parameter int NV_CYC = NV_WRITE_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Two-wire bus
  input  wire pot_pkg::bus_in_t bus_in,
  output var  pot_pkg::bus_out_t bus_out,
  // Address straps
  input  wire logic [1:0]       addr_strap_pins,
  // Tap select and status
  output logic [6:0]            tap_sel,
  output logic                  nv_busy
);
  import pot_pkg::*;

  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic [1:0] strap_s1_ff, strap_s2_ff;
  logic       scl_ff, sda_ff;
  phase_t     phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic       rd_ff, addr_done_ff, nv_pend_ff, drive_low_ff;
  logic [7:0] reg_addr_ff, access_ff;
  logic [6:0] wiper_ff, stored_initial_position_ff;
  logic [31:0] nv_cnt_ff;
  logic [4:0] pwr_cnt_ff;

  wire scl_s  = scl_sync_ff[1];
  wire sda_s  = sda_sync_ff[1];
  wire scl_rise = scl_s & ~scl_ff;
  wire scl_fall = ~scl_s & scl_ff;
  wire start_c  = scl_s & scl_ff & sda_ff & ~sda_s;
  wire stop_c   = scl_s & scl_ff & ~sda_ff & sda_s;
  wire pwr_busy = (pwr_cnt_ff != 5'(POWERUP_CYC));
  wire start_ok = start_c & ~pwr_busy & ~nv_busy;
  wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
  wire id_match = (rx_byte[7:3] == DEV_ID_HI) && (rx_byte[2:1] == strap_s2_ff);
  wire vol_only = (access_ff == ACCESS_VOL_ONLY);
  wire [7:0] rd_val = (reg_addr_ff == REG_ACCESS) ? access_ff :
                      (reg_addr_ff == REG_WIPER) ? {1'b0, vol_only ? wiper_ff : stored_initial_position_ff} : 8'h00;

  assign nv_busy = (nv_cnt_ff != 32'h0);
  assign tap_sel = wiper_ff;
  assign bus_out = '{sda_o: 1'b0, sda_oe: drive_low_ff};

  always_ff @(posedge clk) begin
    scl_sync_ff <= {scl_sync_ff[0], bus_in.scl};
    sda_sync_ff <= {sda_sync_ff[0], bus_in.sda};
    strap_s1_ff <= addr_strap_pins;
    strap_s2_ff <= strap_s1_ff;
    scl_ff <= scl_s;
    sda_ff <= sda_s;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_cnt_ff <= 5'h00;
    end else if (pwr_busy) begin
      pwr_cnt_ff <= pwr_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rd_ff <= 1'b0;
      addr_done_ff <= 1'b0;
      nv_pend_ff <= 1'b0;
      drive_low_ff <= 1'b0;
      reg_addr_ff <= 8'h00;
      access_ff <= 8'h00;
      wiper_ff <= WIPER_RST;
      stored_initial_position_ff <= STORED_INIT_RST;
      nv_cnt_ff <= 32'h0;
    end else begin
      if (nv_busy) begin
        nv_cnt_ff <= nv_cnt_ff - 32'h1;
      end
      if (start_ok) begin
        phase_ff <= ST_ID;
        bit_cnt_ff <= 4'h0;
        addr_done_ff <= 1'b0;
        nv_pend_ff <= 1'b0;
        drive_low_ff <= 1'b0;
      end else if (stop_c) begin
        phase_ff <= ST_IDLE;
        drive_low_ff <= 1'b0;
        if (nv_pend_ff) begin
          nv_cnt_ff <= 32'(NV_CYC);
        end
        nv_pend_ff <= 1'b0;
      end else begin
        case (phase_ff)
          ST_ID, ST_ADDR, ST_WDATA: begin
            if (scl_rise) begin
              shift_ff <= rx_byte;
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                if (phase_ff == ST_ID) begin
                  if (id_match) begin
                    rd_ff <= rx_byte[0];
                    phase_ff <= ST_ACK;
                  end else begin
                    phase_ff <= ST_IDLE;
                  end
                end else if (phase_ff == ST_ADDR) begin
                  reg_addr_ff <= rx_byte;
                  addr_done_ff <= 1'b1;
                  phase_ff <= ST_ACK;
                end else begin
                  phase_ff <= ST_ACK;
                  if (reg_addr_ff == REG_ACCESS) begin
                    access_ff <= rx_byte;
                  end else if (reg_addr_ff == REG_WIPER) begin
                    wiper_ff <= rx_byte[6:0];
                    if (!vol_only) begin
                      stored_initial_position_ff <= rx_byte[6:0];
                      nv_pend_ff <= 1'b1;
                    end
                  end
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall && !drive_low_ff) begin
              drive_low_ff <= 1'b1;
            end else if (scl_fall && drive_low_ff) begin
              bit_cnt_ff <= 4'h0;
              if (rd_ff) begin
                phase_ff <= ST_RDATA;
                shift_ff <= rd_val;
                drive_low_ff <= ~rd_val[7];
              end else begin
                drive_low_ff <= 1'b0;
                phase_ff <= addr_done_ff ? ST_WDATA : ST_ADDR;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              shift_ff <= {shift_ff[6:0], 1'b1};
              if (bit_cnt_ff == 4'h7) begin
                drive_low_ff <= 1'b0;
                phase_ff <= ST_RACK;
              end else begin
                drive_low_ff <= ~shift_ff[6];
              end
            end
          end
          ST_RACK: begin
            // NACK ends the read; ACK loads the next byte at the fall
            if (scl_rise && sda_s) begin
              phase_ff <= ST_IDLE;
            end else if (scl_fall) begin
              bit_cnt_ff <= 4'h0;
              phase_ff <= ST_RDATA;
              shift_ff <= rd_val;
              drive_low_ff <= ~rd_val[7];
            end
          end
          default: begin
            phase_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  property p_open_drain;
    @(posedge clk) disable iff (sys_rst) bus_out.sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");

  property p_out_on_fall;
    @(posedge clk) disable iff (sys_rst)
      (phase_ff == ST_RDATA && $changed(drive_low_ff)) |-> $past(scl_fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("read data changed off falling edge");

  property p_start_ignored;
    @(posedge clk) disable iff (sys_rst) (start_c && nv_busy && !stop_c) |=> phase_ff != ST_ID;
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start accepted while busy");

  property p_nv_start;
    @(posedge clk) disable iff (sys_rst) (stop_c && nv_pend_ff && !start_ok) |=> nv_cnt_ff == 32'(NV_CYC);
  endproperty
  a_nv_start: assert property (p_nv_start) else $error("nv cycle not started");

  property p_tap;
    @(posedge clk) disable iff (sys_rst)
      (phase_ff == ST_WDATA && scl_rise && bit_cnt_ff == 4'h7 && reg_addr_ff == REG_WIPER && !start_ok && !stop_c)
      |=> tap_sel == shift_ff[6:0];
  endproperty
  a_tap: assert property (p_tap) else $error("tap mismatch");

  property p_mismatch;
    @(posedge clk) disable iff (sys_rst)
      (phase_ff == ST_ID && scl_rise && bit_cnt_ff == 4'h7 && !id_match && !start_ok && !stop_c)
      |=> phase_ff == ST_IDLE && !drive_low_ff;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("responded to foreign address");

  property p_vol_only;
    @(posedge clk) disable iff (sys_rst) vol_only && !nv_pend_ff |=> $stable(stored_initial_position_ff);
  endproperty
  a_vol_only: assert property (p_vol_only) else $error("stored value changed");

  property p_ack;
    @(posedge clk) disable iff (sys_rst)
      (phase_ff == ST_ACK && scl_fall && !drive_low_ff && !start_ok && !stop_c) |=> bus_out.sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("ack slot fault");
endmodule : i2c_pot_wiper_slave
`default_nettype wire

/* File: pot_master.sv */
`timescale 1ns/1ps
`default_nettype none
module pot_master (
  // Bus wires
  input  wire logic oe,
  output var  logic scl,
  output wire logic sda
);
  logic drv = 1'b1;
  assign sda = drv & (oe !== 1'b1);
  initial scl = 1'b1;
  // Data bits move only while the clock is low; start and stop change data while it is high
  task automatic bitx(input logic v, output logic s);
    drv = v;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
    #40;
  endtask : bitx
  task automatic start();
    drv = 1'b1;
    #40 scl = 1'b1;
    #80 drv = 1'b0;
    #80 scl = 1'b0;
    #40;
  endtask : start
  task automatic stop();
    drv = 1'b0;
    #40 scl = 1'b1;
    #80 drv = 1'b1;
    #40;
  endtask : stop
  function automatic logic [7:0] id(input logic [1:0] s, input logic r);
    return {pot_pkg::DEV_ID_HI, s, r};
  endfunction : id
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(last, s);
  endtask : rbyte
endmodule : pot_master
`default_nettype wire

/* File: tb_i2c_pot_wiper_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_pot_wiper_slave;
  import pot_pkg::*;
  // Short NV cycle keeps the run brief
  localparam int NV_SIM = 50;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [1:0] addr_strap_pins = 2'b10;
  logic [6:0] tap_sel;
  logic       nv_busy;
  logic       scl;
  wire        sda;
  bus_in_t    bus_in;
  bus_out_t   bus_out;
  int         n_fail = 0;
  int         n_tests = 0;
  logic [2:0] a;
  logic [7:0] d;
  assign bus_in = '{scl: scl, sda: sda};
  pot_master m_u (.oe(bus_out.sda_oe), .scl(scl), .sda(sda));
  i2c_pot_wiper_slave #(.NV_CYC(NV_SIM)) dut_u (.clk(clk), .sys_rst(sys_rst), .bus_in(bus_in),
    .bus_out(bus_out), .addr_strap_pins(addr_strap_pins), .tap_sel(tap_sel), .nv_busy(nv_busy));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    m_u.start();
    m_u.wbyte(m_u.id(addr_strap_pins, 1'b0), a[2]);
    m_u.wbyte(ad, a[1]);
    m_u.wbyte(v, a[0]);
    m_u.stop();
    check("write acks", {5'h00, a}, 8'h07);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    m_u.start();
    m_u.wbyte(m_u.id(addr_strap_pins, 1'b0), a[2]);
    m_u.wbyte(ad, a[1]);
    m_u.start();
    m_u.wbyte(m_u.id(addr_strap_pins, 1'b1), a[0]);
    m_u.rbyte(1'b1, d);
    m_u.stop();
    check("read acks", {5'h00, a}, 8'h07);
    check("read data", d, exp);
    check("sda_o", {7'h00, bus_out.sda_o}, 8'h00);
    check("sda released", {7'h00, bus_out.sda_oe}, 8'h00);
  endtask : rd
  task automatic t_straps();
    for (int s = 0; s < 4; s++) begin
      addr_strap_pins = 2'(s);
      repeat (4) @(negedge clk);
      m_u.start();
      m_u.wbyte(m_u.id(addr_strap_pins ^ 2'(s % 3 + 1), 1'b1), a[1]);
      m_u.stop();
      m_u.start();
      m_u.wbyte(m_u.id(addr_strap_pins, 1'b1), a[0]);
      m_u.rbyte(1'b1, d);
      m_u.stop();
      check("strap acks", {6'h00, a[1:0]}, 8'h01);
    end
    addr_strap_pins = 2'b10;
    $display("test straps done");
  endtask : t_straps
  task automatic t_nv();
    wr(REG_WIPER, 8'h15);
    check("tap nv", {1'b0, tap_sel}, 8'h15);
    repeat (6) @(negedge clk);
    check("busy", {7'h00, nv_busy}, 8'h01);
    m_u.start();
    m_u.wbyte(m_u.id(addr_strap_pins, 1'b0), a[0]);
    m_u.stop();
    check("ack busy", {7'h00, a[0]}, 8'h00);
    check("busy end", {7'h00, nv_busy}, 8'h00);
    for (int i = 0; i < 4 && a[0] !== 1'b1; i++) begin
      m_u.start();
      m_u.wbyte(m_u.id(addr_strap_pins, 1'b0), a[0]);
      m_u.stop();
    end
    check("poll ack", {7'h00, a[0]}, 8'h01);
    rd(REG_WIPER, 8'h15);
    $display("test nv done");
  endtask : t_nv
  task automatic t_vol();
    wr(REG_ACCESS, ACCESS_VOL_ONLY);
    wr(REG_WIPER, {1'b0, WIPER_MAX});
    check("tap max", {1'b0, tap_sel}, {1'b0, WIPER_MAX});
    rd(REG_WIPER, {1'b0, WIPER_MAX});
    wr(REG_WIPER, 8'h00);
    check("tap zero", {1'b0, tap_sel}, 8'h00);
    check("busy vol", {7'h00, nv_busy}, 8'h00);
    wr(REG_ACCESS, 8'h00);
    rd(REG_WIPER, 8'h15);
    $display("test vol done");
  endtask : t_vol
  task automatic t_powerup();
    sys_rst = 1'b1;
    fork
      m_u.start();
      begin
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        check("tap rst", {1'b0, tap_sel}, {1'b0, WIPER_RST});
        check("oe rst", {7'h00, bus_out.sda_oe}, 8'h00);
      end
    join
    m_u.wbyte(m_u.id(addr_strap_pins, 1'b0), a[0]);
    m_u.stop();
    check("ack powerup", {7'h00, a[0]}, 8'h00);
    $display("test powerup done");
  endtask : t_powerup
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (20) @(negedge clk);
    t_straps();
    t_nv();
    t_vol();
    t_powerup();
    finish_test();
  end
  // About three times the expected run
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule : tb_i2c_pot_wiper_slave
`default_nettype wire
